// ### hw/spb_pkg.sv
// Package for the switch status and power budget register slice.
// Assumes an APB slave with 32-bit data and word-aligned byte addresses.
package spb_pkg;

  // Register byte addresses
  localparam logic [11:0] SPB_PBV_BASE      = 12'h0300;
  localparam logic [11:0] SPB_PBV_LAST      = 12'h0324;
  localparam logic [11:0] SPB_SWITCH_STATUS = 12'h0328;
  localparam logic [11:0] SPB_SWITCH_CTRL   = 12'h032C;
  localparam logic [11:0] SPB_BUDGET_INDEX  = 12'h0284;
  localparam logic [11:0] SPB_BUDGET_DATA   = 12'h0288;

  // Power budget array size
  localparam int          SPB_PBV_COUNT     = 10;
  localparam logic [7:0]  SPB_PBV_MAX_INDEX = 8'h09;

  // Synchroniser fill count after fundamental reset; straps latch on it
  localparam logic [2:0]  SPB_STRAP_FILL_LAST = 3'h4;

  // Status field positions
  localparam int SPB_MODE_LSB     = 0;
  localparam int SPB_MODE_MSB     = 2;
  localparam int SPB_DS_CCLK_BIT  = 5;
  localparam int SPB_US_CCLK_BIT  = 6;
  localparam int SPB_MGMT_BIT     = 7;
  localparam int SPB_REFCLK_BIT   = 8;
  localparam int SPB_HALT_BIT     = 9;
  localparam int SPB_LOCK_LSB     = 20;
  localparam int SPB_LOCK_MSB     = 22;
  localparam int SPB_MARKER_LSB   = 28;
  localparam int SPB_MARKER_MSB   = 31;

  // Control field positions
  localparam int SPB_GEN_UNLOCK_BIT = 3;
  localparam int SPB_PBV_UNLOCK_BIT = 4;

  // Operating mode codes
  localparam logic [2:0] SPB_MODE_NORMAL     = 3'h0;
  localparam logic [2:0] SPB_MODE_LOW_LAT    = 3'h2;
  localparam logic [2:0] SPB_MODE_LOAD_LOWLAT = 3'h3;

  // Lock state codes
  localparam logic [2:0] SPB_LOCK_NONE  = 3'h0;
  localparam logic [2:0] SPB_LOCK_FIRST = 3'h2;
  localparam logic [2:0] SPB_LOCK_LAST  = 3'h5;

  // Reset values
  localparam logic [31:0] SPB_WORD_ZERO   = 32'h0000_0000;
  localparam logic [3:0]  SPB_MARKER_RST  = 4'h0;
  localparam logic [2:0]  SPB_LOCK_RST    = 3'h0;

  // Elastic FIFO init values; the low latency one saves 8 ns
  localparam int          SPB_LATENCY_SAVING_NS = 8;
  localparam int          SPB_CLK_PERIOD_NS     = 10;
  localparam logic [3:0]  SPB_EFIFO_INIT_NORMAL = 4'h4;
  localparam logic [3:0]  SPB_EFIFO_INIT_LOWLAT = 4'h3;

endpackage : spb_pkg

// ### hw/spb_status_budget_regs.sv
// Switch status and ten lockable power budget value registers on APB.
// Assumes straps and mode pins arrive asynchronously from pins, the lock
// state comes from the switch core on pclk, and hot_resetn is synchronous
// to pclk. presetn is the fundamental reset.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Ten 32-bit budget value words live from byte address 0x300.
// - With budget unlock set, budget words read and write normally.
// - Budget unlock clear: budget words read-only, writes dropped.
// - Status bits 2:0 report operating mode pins; codes 4 and up reserved.
// - Low latency modes pick the smaller elastic FIFO initial value.
// - Status bit 5 holds downstream common clock strap from reset.
// - Status bit 6 holds upstream common clock strap from reset.
// - Status bit 7 holds management bus slow strap from reset.
// - Status bit 8 holds reference clock mode strap from reset.
// - Status bit 9 holds reset halt strap from reset.
// - Status bits 22:20 report lock state: 0 unlocked, 2..5 locked port.
// - Marker bits 31:28 reset to zero and survive hot reset.
// - Budget unlock is bit 4 of the switch control register.
// - Lockable fields, marker included, accept writes only with unlock.
// - Index selects budget word for readout; index above 9 reads zero.
module spb_status_budget_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        hot_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  operating_mode_code,
  input  wire logic        downstream_common_clock_strap,
  input  wire logic        upstream_common_clock_strap,
  input  wire logic        mgmt_bus_slow_strap,
  input  wire logic        refclk_mode_strap,
  input  wire logic        reset_halt_strap,
  input  wire logic [2:0]  lock_state,
  output logic      [3:0]  elastic_fifo_init_value
);

  // Assertion defaults: every check runs on pclk, off in fundamental reset
  default clocking spb_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  logic [7:0] pin_val;
  logic       strap_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
      pin_s3 <= 8'h00;
    end else begin
      pin_s1 <= {reset_halt_strap, refclk_mode_strap, mgmt_bus_slow_strap,
                 upstream_common_clock_strap, downstream_common_clock_strap,
                 operating_mode_code};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Filtered value follows only agreeing bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_val <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_val[i] <= pin_s3[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Strap capture: a reset cannot load a pin, so straps are caught by the
  // clock once the synchroniser has filled after fundamental reset release.
  logic [2:0] fill_cnt;
  logic [2:0] mode_q;
  logic [4:0] strap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_cnt   <= 3'h0;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      fill_cnt <= 3'(fill_cnt + 3'h1);
      if (fill_cnt == spb_pkg::SPB_STRAP_FILL_LAST) begin
        strap_done <= 1'b1;
      end
    end
  end

  // Straps frozen after capture; mode pins likewise are configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q  <= 3'h0;
      strap_q <= 5'h00;
    end else if (!strap_done && fill_cnt == spb_pkg::SPB_STRAP_FILL_LAST) begin
      mode_q  <= pin_val[2:0];
      strap_q <= pin_val[7:3];
    end
  end

  // Lower latency modes use the smaller elastic FIFO start value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elastic_fifo_init_value <= spb_pkg::SPB_EFIFO_INIT_NORMAL;
    end else if (mode_q == spb_pkg::SPB_MODE_LOW_LAT ||
                 mode_q == spb_pkg::SPB_MODE_LOAD_LOWLAT) begin
      elastic_fifo_init_value <= spb_pkg::SPB_EFIFO_INIT_LOWLAT;
    end else begin
      elastic_fifo_init_value <= spb_pkg::SPB_EFIFO_INIT_NORMAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // APB decode; every access completes in its first access cycle
  logic       wr_en;
  logic       rd_en;
  logic       pbv_hit;
  logic [3:0] pbv_idx;
  logic [31:0] wmask;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pbv_hit = (paddr >= spb_pkg::SPB_PBV_BASE) &&
                   (paddr <= spb_pkg::SPB_PBV_LAST) && (paddr[1:0] == 2'b00);
  assign pbv_idx = 4'(paddr[5:2]);
  assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                    {8{pstrb[0]}}};

  //////////////////////////////////////////////////////////////////////////
  // Switch control bits held here: general unlock and budget unlock
  logic gen_unlock;
  logic pbv_unlock;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_unlock <= 1'b0;
      pbv_unlock <= 1'b0;
    end else if (wr_en && paddr == spb_pkg::SPB_SWITCH_CTRL) begin
      if (pstrb[0]) begin
        gen_unlock <= pwdata[spb_pkg::SPB_GEN_UNLOCK_BIT];
        if (gen_unlock) begin
          pbv_unlock <= pwdata[spb_pkg::SPB_PBV_UNLOCK_BIT];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Budget value words: sticky, no reset beyond fundamental
  logic [31:0] pbv_mem [spb_pkg::SPB_PBV_COUNT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < spb_pkg::SPB_PBV_COUNT; i++) begin
        pbv_mem[i] <= spb_pkg::SPB_WORD_ZERO;
      end
    end else if (wr_en && pbv_hit && pbv_unlock) begin
      pbv_mem[pbv_idx] <= (pbv_mem[pbv_idx] & ~wmask) | (pwdata & wmask);
    end
  end

  // Readout index, 8 bits
  logic [7:0] budget_value_index;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      budget_value_index <= 8'h00;
    end else if (wr_en && paddr == spb_pkg::SPB_BUDGET_INDEX && pstrb[0]) begin
      budget_value_index <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Marker: cleared by fundamental reset only, hot reset leaves it alone
  logic [3:0] marker;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marker <= spb_pkg::SPB_MARKER_RST;
    end else if (wr_en && paddr == spb_pkg::SPB_SWITCH_STATUS &&
                 pstrb[3] && gen_unlock) begin
      marker <=
        pwdata[spb_pkg::SPB_MARKER_MSB:spb_pkg::SPB_MARKER_LSB];
    end
  end

  // Lock state follows the core; hot reset clears it
  logic [2:0] lock_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= spb_pkg::SPB_LOCK_RST;
    end else if (!hot_resetn) begin
      lock_q <= spb_pkg::SPB_LOCK_RST;
    end else begin
      lock_q <= lock_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status word assembly; reserved bits stay zero
  logic [31:0] status_word;

  always_comb begin
    status_word = spb_pkg::SPB_WORD_ZERO;
    status_word[spb_pkg::SPB_MODE_MSB:spb_pkg::SPB_MODE_LSB] = mode_q;
    status_word[spb_pkg::SPB_DS_CCLK_BIT] = strap_q[0];
    status_word[spb_pkg::SPB_US_CCLK_BIT] = strap_q[1];
    status_word[spb_pkg::SPB_MGMT_BIT]    = strap_q[2];
    status_word[spb_pkg::SPB_REFCLK_BIT]  = strap_q[3];
    status_word[spb_pkg::SPB_HALT_BIT]    = strap_q[4];
    status_word[spb_pkg::SPB_LOCK_MSB:spb_pkg::SPB_LOCK_LSB] = lock_q;
    status_word[spb_pkg::SPB_MARKER_MSB:spb_pkg::SPB_MARKER_LSB] = marker;
  end

  // Read mux; unmapped addresses read zero with an error
  logic [31:0] next_prdata;
  logic        next_err;

  always_comb begin
    next_prdata = spb_pkg::SPB_WORD_ZERO;
    next_err    = 1'b0;
    if (pbv_hit) begin
      next_prdata = pbv_mem[pbv_idx];
    end else begin
      case (paddr)
        spb_pkg::SPB_SWITCH_STATUS: next_prdata = status_word;
        spb_pkg::SPB_SWITCH_CTRL: begin
          next_prdata[spb_pkg::SPB_GEN_UNLOCK_BIT] = gen_unlock;
          next_prdata[spb_pkg::SPB_PBV_UNLOCK_BIT] = pbv_unlock;
        end
        spb_pkg::SPB_BUDGET_INDEX: next_prdata[7:0] = budget_value_index;
        spb_pkg::SPB_BUDGET_DATA: begin
          if (budget_value_index <= spb_pkg::SPB_PBV_MAX_INDEX) begin
            next_prdata = pbv_mem[budget_value_index[3:0]];
          end
        end
        default: next_err = 1'b1;
      endcase
    end
  end

  // Registered answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= spb_pkg::SPB_WORD_ZERO;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && next_err;
      prdata  <= (psel && !penable && !pwrite) ? next_prdata
                                               : spb_pkg::SPB_WORD_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks; clock and fundamental reset come from the defaults at the top

  // A locked budget word keeps its old contents through a write
  a_locked_pbv_hold: assert property (
    (wr_en && pready && pbv_hit && !pbv_unlock) |=>
      pbv_mem[$past(pbv_idx)] == $past(pbv_mem[pbv_idx]))
    else $error("budget word changed while locked");

  // An unlocked full-word write lands exactly
  a_unlocked_pbv_write: assert property (
    (wr_en && pready && pbv_hit && pbv_unlock && pstrb == 4'hF) |=>
      pbv_mem[$past(pbv_idx)] == $past(pwdata))
    else $error("budget word write lost");

  // Marker frozen while general unlock is clear
  a_marker_locked: assert property (
    !gen_unlock |=> marker == $past(marker))
    else $error("marker changed while locked");

  // Hot reset alone never touches the marker
  a_marker_hot_reset: assert property (
    (!hot_resetn && !wr_en) |=> marker == $past(marker))
    else $error("marker lost on hot reset");

  // Lock field follows the core one cycle late
  a_lock_tracks: assert property (
    hot_resetn |=> lock_q == $past(lock_state))
    else $error("lock state not tracked");

  // Hot reset shows the upstream port as unlocked
  a_lock_hot_clear: assert property (
    !hot_resetn |=> lock_q == spb_pkg::SPB_LOCK_NONE)
    else $error("lock state kept over hot reset");

  // Captured straps and mode stay put until the next fundamental reset
  a_straps_frozen: assert property (
    strap_done |=> strap_q == $past(strap_q) && mode_q == $past(mode_q))
    else $error("strap changed after capture");

  // Both lower latency modes select the smaller FIFO start value
  a_fifo_lowlat: assert property (
    (mode_q == spb_pkg::SPB_MODE_LOW_LAT ||
     mode_q == spb_pkg::SPB_MODE_LOAD_LOWLAT) |=>
      elastic_fifo_init_value == spb_pkg::SPB_EFIFO_INIT_LOWLAT)
    else $error("low latency FIFO value not applied");

  // Every other mode keeps the normal start value
  a_fifo_normal: assert property (
    (mode_q != spb_pkg::SPB_MODE_LOW_LAT &&
     mode_q != spb_pkg::SPB_MODE_LOAD_LOWLAT) |=>
      elastic_fifo_init_value == spb_pkg::SPB_EFIFO_INIT_NORMAL)
    else $error("normal FIFO value not applied");

  // Reserved status bits always read zero
  a_reserved_zero: assert property (
    status_word[19:10] == 10'h000 && status_word[4:3] == 2'b00 &&
    status_word[27:23] == 5'h00)
    else $error("reserved status bits set");

  // Readout data is latched at the setup edge; a high index gives zero
  a_index_zero: assert property (
    (psel && !penable && !pwrite && paddr == spb_pkg::SPB_BUDGET_DATA &&
     budget_value_index > spb_pkg::SPB_PBV_MAX_INDEX) |=>
      prdata == spb_pkg::SPB_WORD_ZERO)
    else $error("out of range index gave data");

  // Budget unlock only moves while general unlock is set
  a_pbv_unlock_gate: assert property (
    (!gen_unlock) |=> pbv_unlock == $past(pbv_unlock))
    else $error("budget unlock changed while locked");

  c_pbv_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && pready && pbv_hit && pbv_unlock);
  c_pbv_blocked: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && pready && pbv_hit && !pbv_unlock);
  c_marker_write: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && pready && paddr == spb_pkg::SPB_SWITCH_STATUS && gen_unlock);
  c_readout: cover property (@(posedge pclk) disable iff (!presetn)
    rd_en && pready && paddr == spb_pkg::SPB_BUDGET_DATA);

endmodule : spb_status_budget_regs

// ### testbench/spb_status_budget_regs_tb.sv
// Self-checking bench for the switch status and power budget registers.
// Assumes one-cycle APB answers and strap capture within 8 edges of reset.
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
  error_cnt++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module spb_status_budget_regs_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        hot_resetn = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  operating_mode_code = 3'h0;
  logic [4:0]  straps = 5'h00;
  logic [2:0]  lock_state = 3'h0;
  logic [3:0]  elastic_fifo_init_value;
  logic [2:0]  cur_md;
  logic [4:0]  cur_pat;
  int          error_cnt = 0;
  int          samples_checked = 0;

  //////////////////////////////////////////////////////////////////////////
  // Clock, device and watchdog
  always #5 pclk = ~pclk;

  spb_status_budget_regs DUT (
    .pclk                          (pclk),
    .presetn                       (presetn),
    .hot_resetn                    (hot_resetn),
    .psel                          (psel),
    .penable                       (penable),
    .pwrite                        (pwrite),
    .paddr                         (paddr),
    .pwdata                        (pwdata),
    .pstrb                         (pstrb),
    .prdata                        (prdata),
    .pready                        (pready),
    .pslverr                       (pslverr),
    .operating_mode_code           (operating_mode_code),
    .downstream_common_clock_strap (straps[0]),
    .upstream_common_clock_strap   (straps[1]),
    .mgmt_bus_slow_strap           (straps[2]),
    .refclk_mode_strap             (straps[3]),
    .reset_halt_strap              (straps[4]),
    .lock_state                    (lock_state),
    .elastic_fifo_init_value       (elastic_fifo_init_value)
  );

  // Whole run is a few hundred cycles; this span leaves ample margin
  initial begin
    #200_000;
    error_cnt++;
    end_sim();
  end

  //////////////////////////////////////////////////////////////////////////
  // Helpers
  // Expected status word from the straps of the last fundamental reset
  function automatic logic [31:0] st(logic [2:0] lk, logic [3:0] mk);
    return {mk, 5'h00, lk, 10'h000, cur_pat, 2'b00, cur_md};
  endfunction : st

  function automatic logic [31:0] wv(int i);
    return 32'hA5A5_0000 + 32'(i);
  endfunction : wv

  // Fundamental reset with new strap values; capture settles in 8 edges
  task automatic do_reset(logic [2:0] md, logic [4:0] pat);
    @(posedge pclk);
    presetn             <= 1'b0;
    operating_mode_code <= md;
    straps              <= pat;
    cur_md = md;
    cur_pat = pat;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask : do_reset

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    `CHK("wait states", 0, n)
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    `CHK("write error", 1'b0, e)
  endtask : wr

  task automatic chk(string nm, logic [11:0] a, logic [31:0] ex);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK(nm, ex, q)
  endtask : chk

  // Status read against the captured straps and the given lock and marker
  task automatic chk_sts(string nm, logic [2:0] lk, logic [3:0] mk);
    chk(nm, spb_pkg::SPB_SWITCH_STATUS, st(lk, mk));
  endtask : chk_sts

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Mode codes 0 to 3 and reserved 6, straps seen high and low, pins moved after capture
  task automatic t_straps();
    logic [4:0] pats [4] = '{5'h15, 5'h0A, 5'h1F, 5'h03};
    logic [3:0] ef;
    // Low latency modes only come with both common clock straps set
    for (int m = 0; m < 4; m++) begin
      do_reset(3'(m), pats[m]);
      ef = (m >= 2) ? spb_pkg::SPB_EFIFO_INIT_LOWLAT
                    : spb_pkg::SPB_EFIFO_INIT_NORMAL;
      `CHK("fifo init", ef, elastic_fifo_init_value)
      chk_sts("status", 3'h0, 4'h0);
      straps              <= ~pats[m];
      operating_mode_code <= 3'h7;
      repeat (8) @(posedge pclk);
      chk_sts("held", 3'h0, 4'h0);
      `CHK("fifo held", ef, elastic_fifo_init_value)
    end
    // A reserved mode code reads back as pinned, with normal latency
    do_reset(3'h6, 5'h00);
    chk_sts("reserved mode", 3'h0, 4'h0);
    ef = spb_pkg::SPB_EFIFO_INIT_NORMAL;
    `CHK("fifo reserved", ef, elastic_fifo_init_value)
  endtask : t_straps

  // Locking of budget words, direct and indexed readback, unmapped place
  task automatic t_budget();
    logic [31:0] q;
    logic        e;
    wr(spb_pkg::SPB_PBV_BASE, 32'h1234_5678);
    chk("locked word", spb_pkg::SPB_PBV_BASE, 32'h0000_0000);
    wr(spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0010);
    chk("ctrl", spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0000);
    wr(spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0008);
    wr(spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0018);
    chk("ctrl", spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0018);
    for (int i = 0; i < 10; i++) begin
      wr(spb_pkg::SPB_PBV_BASE + 12'(4 * i), wv(i));
    end
    for (int i = 0; i < 10; i++) begin
      chk("word", spb_pkg::SPB_PBV_BASE + 12'(4 * i), wv(i));
    end
    for (int i = 0; i < 12; i++) begin
      wr(spb_pkg::SPB_BUDGET_INDEX, (i == 11) ? 32'h0000_00FF : 32'(i));
      chk("readout", spb_pkg::SPB_BUDGET_DATA, (i < 10) ? wv(i) : 0);
    end
    // Only the strobed byte lane of a budget word changes
    pstrb <= 4'h1;
    wr(spb_pkg::SPB_PBV_BASE + 12'h008, 32'hFFFF_FFFF);
    pstrb <= 4'hF;
    chk("lane", spb_pkg::SPB_PBV_BASE + 12'h008, 32'hA5A5_00FF);
    wr(spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0008);
    wr(spb_pkg::SPB_PBV_BASE + 12'h00C, 32'hFFFF_FFFF);
    chk("relocked", spb_pkg::SPB_PBV_BASE + 12'h00C, wv(3));
    apb(1'b0, 12'h330, 32'h0000_0000, q, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0000_0000, q)
  endtask : t_budget

  // Lock field follows the core's lock code
  task automatic t_lock();
    logic [2:0]  codes [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
    logic [31:0] q;
    logic        e;
    foreach (codes[k]) begin
      lock_state <= codes[k];
      repeat (3) @(posedge pclk);
      apb(1'b0, spb_pkg::SPB_SWITCH_STATUS, 32'h0000_0000, q, e);
      `CHK("lock field", codes[k], q[22:20])
    end
    lock_state <= 3'h0;
    repeat (3) @(posedge pclk);
  endtask : t_lock

  // Marker locking, reserved bits, survival across hot reset only
  task automatic t_marker();
    wr(spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0000);
    wr(spb_pkg::SPB_SWITCH_STATUS, 32'hFFFF_FFFF);
    chk_sts("marker", 3'h0, 4'h0);
    wr(spb_pkg::SPB_SWITCH_CTRL, 32'h0000_0008);
    wr(spb_pkg::SPB_SWITCH_STATUS, 32'hFFFF_FFFF);
    chk_sts("marker", 3'h0, 4'hF);
    // Core reports a lock while hot reset is held: field reads unlocked
    lock_state <= 3'h4;
    hot_resetn <= 1'b0;
    chk_sts("hot marker", 3'h0, 4'hF);
    hot_resetn <= 1'b1;
    chk_sts("hot lock", 3'h4, 4'hF);
    lock_state <= 3'h0;
    chk("hot word", spb_pkg::SPB_PBV_BASE, wv(0));
    do_reset(cur_md, cur_pat);
    chk_sts("cold marker", 3'h0, 4'h0);
  endtask : t_marker

  //////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    do_reset(3'h0, 5'h00);
    t_straps();
    t_budget();
    t_lock();
    t_marker();
    end_sim();
  end
endmodule : spb_status_budget_regs_tb
